/* File: include/stop_ctl_map.svh */
`ifndef STOP_CTL_MAP_SVH
`define STOP_CTL_MAP_SVH
`define ADR_PWR1 3'h0
`define ADR_PWR2 3'h1
`define ADR_OPT 3'h2
`define ADR_RTI 3'h3
`define ADR_STAT 3'h4
`define MSK_PWR1 8'h03
`define MSK_PWR2 8'h03
`define MSK_OPT 8'h07
`define MSK_RTI 8'h0F
`define B_VM_EN 0
`define B_VM_SE 1
`define B_PD_SEL 0
`define B_PPD_SEL 1
`define B_ACK 2
`define B_FLAG 3
`define B_PERMIT 0
`define B_OSC_KEEP 1
`define B_IREF_KEEP 2
`define B_RTI_EXT 3
`define RST_PWR1 8'h00
`define RST_PWR2 8'h00
`define RST_OPT 8'h00
`define RST_RTI 8'h00
`define WAKE_RST_CYC 4'h4
`define RTI_P1 11'h008
`define RTI_P2 11'h020
`define RTI_P3 11'h040
`define RTI_P4 11'h080
`define RTI_P5 11'h100
`define RTI_P6 11'h200
`define RTI_P7 11'h400
`endif

/* File: include/stop_ctl_pkg.sv */
package stop_ctl_pkg;
  typedef enum logic [4:0] {
    MODE_RUN = 5'h01,
    MODE_RETAIN = 5'h02,
    MODE_PARTIAL = 5'h04,
    MODE_FULL = 5'h08,
    MODE_WAKE = 5'h10
  } pmode_type;
endpackage

/* File: include/wake_if.sv */
`timescale 1ns/10ps
interface wake_if #(parameter int K = 8);
  logic rst_n_s;
  logic irq_s;
  logic lfo_s;
  logic ext_s;
  logic [K-1:0] kbi_s;
  logic [2:0] rti_sel;
  logic rti_ext;
  logic rti_run;
  logic rti_tick;
  modport sync (output rst_n_s, irq_s, lfo_s, ext_s, kbi_s);
  modport timer (input lfo_s, ext_s, rti_sel, rti_ext, rti_run, output rti_tick);
  modport ctrl (input rst_n_s, irq_s, kbi_s, rti_tick, output rti_sel, rti_ext, rti_run);
endinterface // wake_if

/* File: rtl/wake_sync.sv */
`timescale 1ns/10ps
module wake_sync #(
  parameter int K = 8,
  parameter int W = K + 4,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // sync reset, low
  input wire logic clk_en, // freezes state when low
  input wire logic [W-1:0] async_in, // {rst_n, irq, lfo, ext, keypad}
  wake_if.sync wif // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_type;
  sync_type st_ff;
  sync_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_ff <= {INIT, INIT};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // only the second stage is visible to the controller
  assign {wif.rst_n_s, wif.irq_s, wif.lfo_s, wif.ext_s, wif.kbi_s} = st_ff.s2;
endmodule // wake_sync

/* File: rtl/wakeup_timer.sv */
`timescale 1ns/10ps
`include "stop_ctl_map.svh"
module wakeup_timer (
  input wire logic mclk, // system clock
  input wire logic nrst, // sync reset, low
  input wire logic clk_en, // freezes state when low
  wake_if.timer wif // source levels in, tick out
);
  typedef struct packed {
    logic prev;
    logic [10:0] cnt;
    logic tick;
  } tmr_type;
  tmr_type st_ff;
  tmr_type nxt_st;
  logic src;

  function automatic logic [10:0] period_of(input logic [2:0] sel);
    case (sel)
      3'h1: period_of = `RTI_P1;
      3'h2: period_of = `RTI_P2;
      3'h3: period_of = `RTI_P3;
      3'h4: period_of = `RTI_P4;
      3'h5: period_of = `RTI_P5;
      3'h6: period_of = `RTI_P6;
      3'h7: period_of = `RTI_P7;
      default: period_of = 11'h7FF;
    endcase
  endfunction

  always_comb begin
    src = wif.rti_ext ? wif.ext_s : wif.lfo_s;
    nxt_st = st_ff;
    nxt_st.prev = src;
    nxt_st.tick = 1'b0;
    if (!wif.rti_run || wif.rti_sel == 3'h0) begin
      nxt_st.cnt = 11'h000;
    end else if (src && !st_ff.prev) begin
      if (st_ff.cnt + 11'h001 >= period_of(wif.rti_sel)) begin
        nxt_st.cnt = 11'h000;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 11'h001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign wif.rti_tick = st_ff.tick;
endmodule // wakeup_timer

/* File: rtl/stop_mode_power_controller.sv */
`timescale 1ns/10ps
`include "stop_ctl_map.svh"
module stop_mode_power_controller #(
  parameter int KEYS = 8
) (
  input wire logic mclk, // 10 MHz system clock
  input wire logic nrst, // sync reset, low
  input wire logic clk_en, // freezes all state when low
  input wire logic [2:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  output logic [7:0] rdata, // read data, cycle after strobe
  input wire logic stop_exec, // cpu executes stop, pulse
  input wire logic debug_entry_enable, // from debug control status
  input wire logic irq_active_low, // interrupt pin polarity config
  input wire logic [KEYS-1:0] keypad_enable, // keypad pin enables
  input wire logic dbg_bgnd_cmd, // background command, pulse
  input wire logic dbg_status_cmd, // memory-with-status command, pulse
  input wire logic reset_pin_n, // reset pin, async
  input wire logic irq_pin, // interrupt pin, async
  input wire logic [KEYS-1:0] keypad_pins, // keypad pins, async
  input wire logic lfo_clk, // ~1 kHz self-clocked source, async
  input wire logic ext_rtc_clk, // external timer clock, async
  output logic cpu_halt, // cpu not clocked
  output logic sys_reset, // power-on style reset of cpu and peripherals
  output logic illegal_op_reset, // illegal-opcode reset, pulse
  output logic irq_wake, // take interrupt-pin vector, pulse
  output logic keypad_wake, // take keypad vector, pulse
  output logic rti_wake, // take wake-timer vector, pulse
  output logic background_entry, // enter background debug, pulse
  output logic dbg_stop_error, // status error for stop, pulse
  output logic dbg_limited, // only limited debug commands accepted
  output logic periph_clk_en, // peripheral clock enable
  output logic debug_clk_en, // debug logic clock enable
  output logic osc_run, // oscillator running
  output logic iref_run, // internal reference running
  output logic lfo_en, // 1 kHz source enable
  output logic regulator_full, // full regulation, else standby
  output logic converter_halt, // converter in standby, no conversions
  output logic ram_power, // ram supplied
  output logic pin_hold, // pin states latched
  output logic pin_force_reset, // pins forced to reset state
  output logic keypad_off // keypad block disabled
);
  typedef struct packed {
    stop_ctl_pkg::pmode_type mode;
    logic [3:0] wcnt;
    logic wpart;
    logic dbg_stop;
    logic vm_stop;
    logic [7:0] pwr1;
    logic [7:0] pwr2;
    logic [7:0] opt;
    logic [7:0] periodic_wakeup_timer;
    logic flag;
    logic hold;
    logic [7:0] rdata;
    logic halt;
    logic sreset;
    logic ill;
    logic irqw;
    logic kbiw;
    logic rtiw;
    logic bgnd;
    logic derr;
    logic dlim;
    logic pclk;
    logic dclk;
    logic osc;
    logic iref;
    logic lfo;
    logic regf;
    logic conv;
    logic ram;
    logic pforce;
    logic koff;
    logic rext;
    logic rrun;
  } ctl_type;

  localparam ctl_type RST_ST = '{
    mode: stop_ctl_pkg::MODE_RUN,
    pwr1: `RST_PWR1,
    pwr2: `RST_PWR2,
    opt: `RST_OPT,
    periodic_wakeup_timer: `RST_RTI,
    pclk: 1'b1,
    dclk: 1'b1,
    osc: 1'b1,
    iref: 1'b1,
    regf: 1'b1,
    ram: 1'b1,
    default: '0
  };

  ctl_type st_ff;
  ctl_type nxt_st;
  logic irq_hit;
  logic kbi_hit;
  logic in_stop;
  logic retain;

  wake_if #(.K(KEYS)) wif ();

  wake_sync #(.K(KEYS)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .clk_en(clk_en),
    .async_in({reset_pin_n, irq_pin, lfo_clk, ext_rtc_clk, keypad_pins}),
    .wif(wif)
  );

  wakeup_timer u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .clk_en(clk_en),
    .wif(wif)
  );

  // enter the reset hold; pwr1, pwr2, opt and periodic_wakeup_timer return to defaults
  function automatic ctl_type to_wake(input ctl_type s, input logic part);
    ctl_type r;
    r = s;
    r.mode = stop_ctl_pkg::MODE_WAKE;
    r.wcnt = `WAKE_RST_CYC;
    r.wpart = part;
    r.pwr1 = `RST_PWR1;
    r.pwr2 = `RST_PWR2;
    r.opt = `RST_OPT;
    r.periodic_wakeup_timer = `RST_RTI;
    return r;
  endfunction

  always_comb begin
    irq_hit = irq_active_low ? !wif.irq_s : wif.irq_s;
    kbi_hit = |(wif.kbi_s & keypad_enable);
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    nxt_st.ill = 1'b0;
    nxt_st.irqw = 1'b0;
    nxt_st.kbiw = 1'b0;
    nxt_st.rtiw = 1'b0;
    nxt_st.bgnd = 1'b0;
    nxt_st.derr = 1'b0;
    if (rd_stb) begin
      case (addr)
        `ADR_PWR1: nxt_st.rdata = st_ff.pwr1;
        `ADR_PWR2: nxt_st.rdata = st_ff.pwr2 | {4'h0, st_ff.flag, 3'h0};
        `ADR_OPT: nxt_st.rdata = st_ff.opt;
        `ADR_RTI: nxt_st.rdata = st_ff.periodic_wakeup_timer;
        `ADR_STAT: nxt_st.rdata = {2'h0, st_ff.hold, st_ff.mode};
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    if (wr_stb && st_ff.mode == stop_ctl_pkg::MODE_RUN) begin
      case (addr)
        `ADR_PWR1: nxt_st.pwr1 = wdata & `MSK_PWR1;
        `ADR_PWR2: begin
          nxt_st.pwr2 = wdata & `MSK_PWR2;
          if (wdata[`B_ACK]) begin
            nxt_st.flag = 1'b0;
            nxt_st.hold = 1'b0;
          end
        end
        `ADR_OPT: nxt_st.opt = wdata & `MSK_OPT;
        `ADR_RTI: nxt_st.periodic_wakeup_timer = wdata & `MSK_RTI;
        default: nxt_st.rdata = nxt_st.rdata;
      endcase
    end
    case (st_ff.mode)
      stop_ctl_pkg::MODE_RUN: begin
        if (!wif.rst_n_s) begin
          nxt_st = to_wake(nxt_st, 1'b0);
        end else if (stop_exec) begin
          nxt_st.dbg_stop = debug_entry_enable;
          nxt_st.vm_stop = st_ff.pwr1[`B_VM_EN] & st_ff.pwr1[`B_VM_SE];
          if (!st_ff.opt[`B_PERMIT]) begin
            nxt_st.ill = 1'b1;
          end else if (!st_ff.pwr2[`B_PD_SEL] || debug_entry_enable
                       || st_ff.pwr1[`B_VM_SE]) begin
            nxt_st.mode = stop_ctl_pkg::MODE_RETAIN;
          end else if (st_ff.pwr2[`B_PPD_SEL]) begin
            nxt_st.mode = stop_ctl_pkg::MODE_PARTIAL;
            nxt_st.hold = 1'b1;
          end else begin
            nxt_st.mode = stop_ctl_pkg::MODE_FULL;
          end
        end
      end
      stop_ctl_pkg::MODE_RETAIN: begin
        if (!wif.rst_n_s) begin
          nxt_st = to_wake(nxt_st, 1'b0);
        end else if (irq_hit || kbi_hit || wif.rti_tick) begin
          nxt_st.mode = stop_ctl_pkg::MODE_RUN;
          nxt_st.irqw = irq_hit;
          nxt_st.kbiw = kbi_hit;
          nxt_st.rtiw = wif.rti_tick;
        end else if (dbg_bgnd_cmd && st_ff.dbg_stop) begin
          nxt_st.mode = stop_ctl_pkg::MODE_RUN;
          nxt_st.bgnd = 1'b1;
        end
      end
      stop_ctl_pkg::MODE_PARTIAL: begin
        // interrupt pin is active low here whatever its configuration
        if (!wif.rst_n_s || !wif.irq_s || wif.rti_tick) begin
          nxt_st = to_wake(nxt_st, 1'b1);
        end
      end
      stop_ctl_pkg::MODE_FULL: begin
        if (!wif.rst_n_s || !wif.irq_s) begin
          nxt_st = to_wake(nxt_st, 1'b0);
        end
      end
      stop_ctl_pkg::MODE_WAKE: begin
        if (st_ff.wcnt != 4'h0) begin
          nxt_st.wcnt = st_ff.wcnt - 4'h1;
        end else if (wif.rst_n_s) begin
          nxt_st.mode = stop_ctl_pkg::MODE_RUN;
          // set after the acknowledge handling, so a set wins
          if (st_ff.wpart) begin
            nxt_st.flag = 1'b1;
          end
        end
      end
      default: nxt_st.mode = stop_ctl_pkg::MODE_RUN;
    endcase
    in_stop = nxt_st.mode == stop_ctl_pkg::MODE_RETAIN
              || nxt_st.mode == stop_ctl_pkg::MODE_PARTIAL
              || nxt_st.mode == stop_ctl_pkg::MODE_FULL;
    retain = nxt_st.mode == stop_ctl_pkg::MODE_RETAIN;
    if (dbg_status_cmd && st_ff.mode != stop_ctl_pkg::MODE_RUN) begin
      nxt_st.derr = 1'b1;
    end
    nxt_st.dlim = in_stop;
    nxt_st.halt = in_stop || nxt_st.mode == stop_ctl_pkg::MODE_WAKE;
    nxt_st.sreset = nxt_st.mode == stop_ctl_pkg::MODE_WAKE;
    nxt_st.pclk = !in_stop;
    nxt_st.dclk = !in_stop || (retain && nxt_st.dbg_stop);
    nxt_st.regf = !in_stop || (retain && (nxt_st.dbg_stop || nxt_st.vm_stop));
    nxt_st.osc = !in_stop
                 || (retain && (nxt_st.opt[`B_OSC_KEEP] || nxt_st.dbg_stop));
    nxt_st.iref = !in_stop
                  || (retain && (nxt_st.opt[`B_IREF_KEEP] || nxt_st.dbg_stop));
    nxt_st.conv = in_stop;
    nxt_st.ram = nxt_st.mode != stop_ctl_pkg::MODE_FULL;
    nxt_st.pforce = nxt_st.mode == stop_ctl_pkg::MODE_FULL;
    nxt_st.koff = nxt_st.mode == stop_ctl_pkg::MODE_PARTIAL
                  || nxt_st.mode == stop_ctl_pkg::MODE_FULL;
    nxt_st.lfo = nxt_st.periodic_wakeup_timer[2:0] != 3'h0
                 && nxt_st.mode != stop_ctl_pkg::MODE_FULL
                 && !(retain && nxt_st.dbg_stop);
    nxt_st.rext = nxt_st.periodic_wakeup_timer[`B_RTI_EXT]
                  && nxt_st.mode != stop_ctl_pkg::MODE_PARTIAL;
    nxt_st.rrun = nxt_st.periodic_wakeup_timer[2:0] != 3'h0
                  && nxt_st.mode != stop_ctl_pkg::MODE_FULL
                  && (nxt_st.rext || nxt_st.lfo);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_ff <= RST_ST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign wif.rti_sel = st_ff.periodic_wakeup_timer[2:0];
  assign wif.rti_ext = st_ff.rext;
  assign wif.rti_run = st_ff.rrun;
  assign rdata = st_ff.rdata;
  assign cpu_halt = st_ff.halt;
  assign sys_reset = st_ff.sreset;
  assign illegal_op_reset = st_ff.ill;
  assign irq_wake = st_ff.irqw;
  assign keypad_wake = st_ff.kbiw;
  assign rti_wake = st_ff.rtiw;
  assign background_entry = st_ff.bgnd;
  assign dbg_stop_error = st_ff.derr;
  assign dbg_limited = st_ff.dlim;
  assign periph_clk_en = st_ff.pclk;
  assign debug_clk_en = st_ff.dclk;
  assign osc_run = st_ff.osc;
  assign iref_run = st_ff.iref;
  assign lfo_en = st_ff.lfo;
  assign regulator_full = st_ff.regf;
  assign converter_halt = st_ff.conv;
  assign ram_power = st_ff.ram;
  assign pin_hold = st_ff.hold;
  assign pin_force_reset = st_ff.pforce;
  assign keypad_off = st_ff.koff;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_illegal_stop: assert property (
    clk_en && stop_exec && st_ff.mode == stop_ctl_pkg::MODE_RUN && wif.rst_n_s
    && !st_ff.opt[`B_PERMIT] |=> illegal_op_reset && !cpu_halt)
    else $error("stop without permit did not force reset");

  a_monitor_refuse: assert property (
    clk_en && stop_exec && st_ff.mode == stop_ctl_pkg::MODE_RUN && wif.rst_n_s
    && st_ff.opt[`B_PERMIT] && st_ff.pwr1[`B_VM_SE]
    |=> st_ff.mode == stop_ctl_pkg::MODE_RETAIN && pin_hold == $past(pin_hold))
    else $error("power-down entered with monitor enabled in stop");

  a_debug_fallback: assert property (
    clk_en && stop_exec && st_ff.mode == stop_ctl_pkg::MODE_RUN && wif.rst_n_s
    && st_ff.opt[`B_PERMIT] && debug_entry_enable
    |=> st_ff.mode == stop_ctl_pkg::MODE_RETAIN && debug_clk_en && regulator_full)
    else $error("debug enabled stop left retention stop");

  a_partial_hold: assert property (
    st_ff.mode == stop_ctl_pkg::MODE_PARTIAL |-> pin_hold && ram_power && keypad_off)
    else $error("pins not latched in partial power-down");

  a_partial_exit: assert property (
    clk_en && st_ff.mode == stop_ctl_pkg::MODE_PARTIAL && wif.rst_n_s && wif.irq_s
    && !wif.rti_tick |=> st_ff.mode == stop_ctl_pkg::MODE_PARTIAL)
    else $error("partial power-down left without wake source");

  a_ack_release: assert property (
    clk_en && wr_stb && addr == `ADR_PWR2 && wdata[`B_ACK]
    && st_ff.mode == stop_ctl_pkg::MODE_RUN |=> !pin_hold && !st_ff.flag)
    else $error("acknowledge did not release latches");

  a_periph_gated: assert property (
    st_ff.mode inside {stop_ctl_pkg::MODE_RETAIN, stop_ctl_pkg::MODE_PARTIAL,
    stop_ctl_pkg::MODE_FULL} |-> !periph_clk_en && converter_halt && dbg_limited)
    else $error("peripheral clock running in stop");

  a_rti_sel_off: assert property (
    st_ff.periodic_wakeup_timer[2:0] == 3'h0 |-> !lfo_en && !wif.rti_run ##1 !wif.rti_tick)
    else $error("wake timer active with zero period select");

  a_dbg_error: assert property (
    clk_en && dbg_status_cmd && st_ff.mode == stop_ctl_pkg::MODE_RETAIN
    |=> dbg_stop_error)
    else $error("status command in stop gave no error");

  a_full_pins: assert property (
    st_ff.mode == stop_ctl_pkg::MODE_FULL |-> pin_force_reset && !ram_power && !lfo_en)
    else $error("full power-down pins not forced");

  a_wake_flag: assert property (
    clk_en && st_ff.mode == stop_ctl_pkg::MODE_WAKE && st_ff.wpart
    && st_ff.wcnt == 4'h0 && wif.rst_n_s |=> st_ff.flag && pin_hold == $past(st_ff.hold))
    else $error("recovery flag not set after partial wake");
endmodule // stop_mode_power_controller

/* File: tb/cpu_model.sv */
`timescale 1ns/10ps
module cpu_model (
  input wire logic mclk, // system clock
  input wire logic stop_req, // bench asks for a stop instruction
  input wire logic bgnd_req, // bench asks for a background command
  input wire logic stat_req, // bench asks for a status command
  input wire logic dbg_en, // debug entry enable level
  input wire logic cpu_halt, // core not clocked
  input wire logic [5:0] ev, // {illegal, irq, key, rti, bgnd, dbg err}
  output logic stop_exec, // stop instruction executed
  output logic dbg_bgnd_cmd, // background command
  output logic dbg_status_cmd, // memory-with-status command
  output logic [5:0][31:0] cnt // vectors taken and answers seen
);
  initial begin
    stop_exec = 1'b0;
    dbg_bgnd_cmd = 1'b0;
    dbg_status_cmd = 1'b0;
    for (int i = 0; i < 6; i++) cnt[i] = 32'h0;
  end
  always @(posedge mclk) begin
    // a halted core cannot execute another stop
    stop_exec <= stop_req & ~cpu_halt;
    dbg_bgnd_cmd <= bgnd_req & dbg_en;
    dbg_status_cmd <= stat_req;
    for (int i = 0; i < 6; i++)
      if (ev[i] === 1'b1) cnt[i] <= cnt[i] + 32'h1;
  end
endmodule // cpu_model

/* File: tb/tb.sv */
`timescale 1ns/10ps
`include "stop_ctl_map.svh"
module tb;
  logic mclk, nrst, clk_en, wr_stb, rd_stb, debug_entry_enable, irq_active_low;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, keypad_enable, keypad_pins, d;
  logic reset_pin_n, irq_pin, lfo_clk, ext_rtc_clk, stop_req, bgnd_req, stat_req;
  logic stop_exec, dbg_bgnd_cmd, dbg_status_cmd, cpu_halt, sys_reset, illegal_op_reset;
  logic irq_wake, keypad_wake, rti_wake, background_entry, dbg_stop_error, dbg_limited;
  logic periph_clk_en, debug_clk_en, osc_run, iref_run, lfo_en, regulator_full;
  logic converter_halt, ram_power, pin_hold, pin_force_reset, keypad_off;
  logic [5:0][31:0] cnt;
  int exp_cnt [0:5];
  int fails, checks_done, cycles, seed;
  stop_mode_power_controller #(.KEYS(8)) stop_mode_power_controller_i (.mclk(mclk),
    .nrst(nrst), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .stop_exec(stop_exec),
    .debug_entry_enable(debug_entry_enable), .irq_active_low(irq_active_low),
    .keypad_enable(keypad_enable), .dbg_bgnd_cmd(dbg_bgnd_cmd),
    .dbg_status_cmd(dbg_status_cmd), .reset_pin_n(reset_pin_n), .irq_pin(irq_pin),
    .keypad_pins(keypad_pins), .lfo_clk(lfo_clk), .ext_rtc_clk(ext_rtc_clk),
    .cpu_halt(cpu_halt), .sys_reset(sys_reset), .illegal_op_reset(illegal_op_reset),
    .irq_wake(irq_wake), .keypad_wake(keypad_wake), .rti_wake(rti_wake),
    .background_entry(background_entry), .dbg_stop_error(dbg_stop_error),
    .dbg_limited(dbg_limited), .periph_clk_en(periph_clk_en),
    .debug_clk_en(debug_clk_en), .osc_run(osc_run), .iref_run(iref_run),
    .lfo_en(lfo_en), .regulator_full(regulator_full), .converter_halt(converter_halt),
    .ram_power(ram_power), .pin_hold(pin_hold), .pin_force_reset(pin_force_reset),
    .keypad_off(keypad_off));
  cpu_model cpu_model_i (.mclk(mclk), .stop_req(stop_req), .bgnd_req(bgnd_req),
    .stat_req(stat_req), .dbg_en(debug_entry_enable), .cpu_halt(cpu_halt),
    .ev({illegal_op_reset, irq_wake, keypad_wake, rti_wake, background_entry,
    dbg_stop_error}), .stop_exec(stop_exec), .dbg_bgnd_cmd(dbg_bgnd_cmd),
    .dbg_status_cmd(dbg_status_cmd), .cnt(cnt));
  always #50 mclk = ~mclk;
  // slow source stops while the design gates it off
  always #370 lfo_clk = ~lfo_clk & lfo_en;
  always #530 ext_rtc_clk = ~ext_rtc_clk;
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      final_report;
    end
  end
  task bad(input string m);
    $display("unexpected at %0t: %s", $time, m);
    fails++;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task chk_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(posedge mclk);
    checks_done++;
    if (rdata !== e) bad($sformatf("read %0d got %h want %h", a, rdata, e));
  endtask
  task chk_bit(input logic v, input logic e, input string m);
    checks_done++;
    if (v !== e) bad(m);
  endtask
  task chk_cnt;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      checks_done++;
      if (cnt[i] !== exp_cnt[i]) bad($sformatf("event %0d count %0d", i, cnt[i]));
    end
  endtask
  task pulse(input int which);
    @(posedge mclk);
    if (which == 0) stop_req <= 1'b1;
    else if (which == 1) stat_req <= 1'b1;
    else bgnd_req <= 1'b1;
    @(posedge mclk);
    stop_req <= 1'b0;
    stat_req <= 1'b0;
    bgnd_req <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task wake_run;
    for (int i = 0; i < 300 && !(cpu_halt === 1'b0 && sys_reset === 1'b0); i++)
      @(posedge mclk);
    if (cpu_halt !== 1'b0) bad("no return to run");
  endtask
  initial begin
    seed = 32'h169A;
    {mclk, nrst, wr_stb, rd_stb, debug_entry_enable, lfo_clk, ext_rtc_clk} = 7'h00;
    {stop_req, bgnd_req, stat_req, addr, wdata, keypad_enable} = 22'h000000;
    {clk_en, irq_active_low, reset_pin_n, irq_pin} = 4'hF;
    keypad_pins = 8'($random(seed));
    for (int i = 0; i < 6; i++) exp_cnt[i] = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    for (int a = 0; a < 6; a++) chk_reg(3'(a), a == 4 ? 8'h01 : 8'h00);
    d = 8'($random(seed));
    wr(`ADR_PWR1, d);
    chk_reg(`ADR_PWR1, d & `MSK_PWR1);
    wr(`ADR_RTI, d);
    wr(3'h5, d);
    chk_reg(`ADR_RTI, d & `MSK_RTI);
    chk_reg(3'h5, 8'h00);
    wr(`ADR_PWR1, 8'h00);
    wr(`ADR_RTI, 8'h00);
    $display("test registers done");
    pulse(0);
    exp_cnt[5]++;
    chk_cnt;
    chk_reg(`ADR_STAT, {3'b000, stop_ctl_pkg::MODE_RUN});
    $display("test no permit done");
    wr(`ADR_OPT, 8'h01);
    wr(`ADR_PWR2, 8'h03);
    irq_active_low <= 1'b0;
    pulse(0);
    chk_reg(`ADR_STAT, {3'b001, stop_ctl_pkg::MODE_PARTIAL});
    chk_bit(periph_clk_en, 1'b0, "peripheral clock on");
    chk_bit(osc_run | iref_run, 1'b0, "clock source on");
    chk_bit(regulator_full, 1'b0, "regulator full");
    chk_bit(keypad_off & converter_halt, 1'b1, "keypad or converter on");
    pulse(1);
    exp_cnt[0]++;
    irq_pin <= 1'b0;
    wake_run;
    irq_pin <= 1'b1;
    chk_bit(pin_hold, 1'b1, "pins released early");
    chk_reg(`ADR_PWR2, 8'h08);
    chk_reg(`ADR_OPT, 8'h00);
    chk_cnt;
    wr(`ADR_PWR2, 8'h04);
    chk_reg(`ADR_PWR2, 8'h00);
    chk_bit(pin_hold, 1'b0, "pins still held");
    $display("test partial done");
    wr(`ADR_OPT, 8'h01);
    wr(`ADR_PWR1, 8'h03);
    wr(`ADR_PWR2, 8'h03);
    irq_active_low <= 1'b1;
    pulse(0);
    chk_reg(`ADR_STAT, {3'b000, stop_ctl_pkg::MODE_RETAIN});
    chk_bit(regulator_full, 1'b1, "regulator standby");
    chk_bit(periph_clk_en, 1'b0, "peripheral clock on");
    repeat (200) @(posedge mclk);
    chk_reg(`ADR_STAT, {3'b000, stop_ctl_pkg::MODE_RETAIN});
    irq_pin <= 1'b0;
    wake_run;
    irq_pin <= 1'b1;
    exp_cnt[4]++;
    chk_cnt;
    clk_en <= 1'b0;
    wr(`ADR_PWR1, 8'h00);
    clk_en <= 1'b1;
    chk_reg(`ADR_PWR1, 8'h03);
    $display("test retention done");
    wr(`ADR_PWR1, 8'h00);
    wr(`ADR_PWR2, 8'h01);
    wr(`ADR_RTI, 8'h01);
    debug_entry_enable <= 1'b1;
    pulse(0);
    chk_reg(`ADR_STAT, {3'b000, stop_ctl_pkg::MODE_RETAIN});
    chk_bit(debug_clk_en & regulator_full, 1'b1, "debug clock or regulator off");
    chk_bit(lfo_en | periph_clk_en, 1'b0, "slow source or peripheral on");
    pulse(1);
    pulse(2);
    exp_cnt[0]++;
    exp_cnt[1]++;
    wake_run;
    chk_cnt;
    debug_entry_enable <= 1'b0;
    $display("test debug done");
    wr(`ADR_PWR2, 8'h00);
    pulse(0);
    wake_run;
    exp_cnt[2]++;
    chk_cnt;
    $display("test wake timer done");
    wr(`ADR_RTI, 8'h00);
    d = 8'($random(seed)) | 8'h01;
    keypad_enable <= d;
    keypad_pins <= 8'h00;
    pulse(0);
    chk_reg(`ADR_STAT, {3'b000, stop_ctl_pkg::MODE_RETAIN});
    keypad_pins <= d;
    wake_run;
    exp_cnt[3]++;
    chk_cnt;
    $display("test keypad done");
    wr(`ADR_PWR2, 8'h01);
    pulse(0);
    chk_reg(`ADR_STAT, {3'b000, stop_ctl_pkg::MODE_FULL});
    chk_bit(pin_force_reset & keypad_off, 1'b1, "pins or keypad not reset");
    chk_bit(osc_run | ram_power, 1'b0, "oscillator or ram on");
    reset_pin_n <= 1'b0;
    repeat (10) @(posedge mclk);
    chk_bit(sys_reset, 1'b1, "no wake reset");
    reset_pin_n <= 1'b1;
    wake_run;
    chk_reg(`ADR_PWR2, 8'h00);
    chk_cnt;
    $display("test full done");
    final_report;
  end
endmodule // tb
